// ===== inc/dbrs_pkg.sv
// Package: constants and carrier types for the DRAM bit recorder sequencer
package dbrs_pkg;

  // Address geometry
  localparam int ADDR_PART_W = 10;
  localparam int LINEAR_ADDR_W = 20;
  localparam int MEM_LOCATIONS = 1048576;
  localparam int LOW_BYTE_W = 8;
  localparam int HIGH_BITS_W = 2;
  localparam logic [9:0] ADDR_PART_RST = 10'h000;

  // Refresh schedule
  localparam int MEM_ROWS = 512;
  localparam int REFRESH_WINDOW_MS = 8;
  localparam int CLK_MHZ = 100;
  localparam int BURST_PERIOD_US = 125;
  localparam int BURST_PERIOD_CYC = BURST_PERIOD_US * CLK_MHZ;
  localparam logic [8:0] BURST_LEN = 9'h008;
  localparam logic [8:0] FULL_BURST_LEN = 9'h100;
  localparam logic [1:0] FULL_BURST_COUNT = 2'h2;

  // Strobe step timing, last step count; each strobe phase except ST_DONE is held one cycle more
  localparam int STEP_NS = 30;
  localparam int CLK_NS = 10;
  localparam logic [3:0] STEP_CYC = 4'((STEP_NS + CLK_NS - 1) / CLK_NS);

  // Strobe reset levels (inactive high)
  localparam logic STROBE_IDLE = 1'b1;

  // Pins driven toward the memory
  typedef struct packed {
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_strobe_n;
    logic [LOW_BYTE_W-1:0] addr_low;
    logic [HIGH_BITS_W-1:0] addr_high;
    logic data;
  } dbrs_mem_out_t;

  // Buffered playback word
  typedef struct packed {
    logic bit_val;
  } dbrs_word_t;

endpackage : dbrs_pkg

// ===== hdl/dbrs_buf.sv
// Two-entry valid/ready buffer for playback bits
`timescale 1ns/1ps
module dbrs_buf (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input dbrs_pkg::dbrs_word_t in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output dbrs_pkg::dbrs_word_t out_data_out
);

  dbrs_pkg::dbrs_word_t mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  // Handshakes; ready is honest full
  assign push = in_valid_in && (count != 2'h2);
  assign pop = out_valid_out && out_ready_in;
  assign in_ready_out = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out = mem[rd_ptr];

  // Storage write
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : dbrs_buf

// ===== hdl/dbrs_seq.sv
// Top: sequencer driving a DRAM as a bit-serial recorder
// Operation
// [RULE1] Refresh: column strobe low, row low, column high, row high per cycle
// [RULE2] Memory takes refresh row from own counter; address bus is don't-care
// [RULE3] All 512 rows refreshed within every 8 ms
// [RULE4] Burst of eight refresh cycles every 125 us; length sets schedule
// [RULE5] Full refresh is two back-to-back bursts of 256 cycles
// [RULE6] Keep 20-bit linear address as 10-bit row and column halves
// [RULE7] After each access bump row; row wrap clears it and bumps column
// [RULE8] Column overflow clears column and raises end flag ending recording
// [RULE9] Read: after column strobe low, capture memory data to playback bit
// [RULE10] Column strobe goes low while column address is stable on bus
// [RULE11] Read ends by raising row strobe then column strobe
// [RULE12] Address part placed as low byte plus two high bits, cleared first
// [RULE13] Write: row, row strobe, data and column, write, column, release all
// [RULE14] Record: refresh, write, advance until end; then play loop forever
// [RULE15] No refresh starts during an access; pending refresh runs between
// [RULE16] Reset: strobes high, address and flag clear, refresh before access
`timescale 1ns/1ps
module dbrs_seq (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Recording stream
  input wire logic rec_bit_in,
  // Playback stream
  output logic play_valid_out,
  input wire logic play_ready_in,
  output logic play_bit_out,
  output logic end_of_memory_out,
  // Memory pins
  output logic row_strobe_n_out,
  output logic col_strobe_n_out,
  output logic write_strobe_n_out,
  output logic [7:0] mem_addr_low_out,
  output logic [1:0] mem_addr_high_out,
  output logic mem_data_out,
  input wire logic mem_data_in,
  // Full-array refresh request (level)
  input wire logic full_refresh_in
);

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_REF_A = 8'h02,
    ST_REF_B = 8'h04,
    ST_REF_C = 8'h08,
    ST_REF_D = 8'h10,
    ST_ROW = 8'h20,
    ST_COL = 8'h40,
    ST_DONE = 8'h80
  } dbrs_state_t;

  dbrs_state_t state;
  logic [3:0] step_cnt;
  logic step_done;
  logic [8:0] ref_left;
  logic [1:0] bursts_left;
  logic [13:0] period_cnt;
  logic ref_pending;
  logic init_done;
  logic [9:0] row_addr;
  logic [9:0] col_addr;
  logic recording;
  logic capture;
  logic buf_ready;
  dbrs_pkg::dbrs_word_t play_word;
  dbrs_pkg::dbrs_word_t buf_out;
  logic buf_valid;
  logic [3:0] phase;
  logic [7:0] row_addr_low_byte;
  logic [1:0] row_addr_high_bits;
  logic [7:0] col_addr_low_byte;
  logic [1:0] col_addr_high_bits;
  logic address_advance;
  logic [10:0] next_row;
  logic [10:0] next_col;

  // Split each address part into the byte and two-bit halves [RULE6]
  assign row_addr_low_byte = row_addr[7:0];
  assign row_addr_high_bits = row_addr[9:8];
  assign col_addr_low_byte = col_addr[7:0];
  assign col_addr_high_bits = col_addr[9:8];
  assign step_done = (step_cnt == dbrs_pkg::STEP_CYC);
  assign next_row = {1'b0, row_addr} + 11'h001;
  assign next_col = {1'b0, col_addr} + 11'h001;

  // Phase timer: every strobe phase except ST_DONE holds STEP_CYC+1 cycles for setup margin
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      step_cnt <= 4'h0;
    end else if (state == ST_IDLE || step_done) begin
      step_cnt <= 4'h0;
    end else begin
      step_cnt <= step_cnt + 4'h1;
    end
  end

  // 125 us schedule; a due burst waits in ref_pending [RULE4] [RULE3]
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      period_cnt <= 14'h0000;
      ref_pending <= 1'b1; // Initial burst before first access [RULE16]
    end else begin
      if (period_cnt == 14'(dbrs_pkg::BURST_PERIOD_CYC - 1)) begin
        period_cnt <= 14'h0000;
        ref_pending <= 1'b1; // Set beats clear in the same cycle
      end else begin
        period_cnt <= period_cnt + 14'h0001;
        if (state == ST_IDLE && ref_pending) begin
          ref_pending <= 1'b0;
        end
      end
    end
  end

  // Access phase: 0..3 steps inside ST_COL, 4 during ST_DONE, cleared to 0 elsewhere
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase <= 4'h0;
    end else if (state != ST_COL) begin
      phase <= 4'h0;
    end else if (step_done) begin
      phase <= phase + 4'h1;
    end
  end

  // Main sequencer
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      ref_left <= 9'h000;
      bursts_left <= 2'h0;
      init_done <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          // Refresh only starts here, never mid-access [RULE15]
          if (ref_pending || !init_done) begin
            if (full_refresh_in) begin
              ref_left <= dbrs_pkg::FULL_BURST_LEN; // [RULE5]
              bursts_left <= dbrs_pkg::FULL_BURST_COUNT - 2'h1;
            end else begin
              ref_left <= dbrs_pkg::BURST_LEN; // [RULE4]
              bursts_left <= 2'h0;
            end
            state <= ST_REF_A;
          end else if (init_done && buf_ready) begin
            state <= ST_ROW; // Stalls while playback buffer is full
          end
        end
        // CAS low, RAS low, CAS high, RAS high [RULE1]
        ST_REF_A: if (step_done) state <= ST_REF_B;
        ST_REF_B: if (step_done) state <= ST_REF_C;
        ST_REF_C: if (step_done) state <= ST_REF_D;
        ST_REF_D: begin
          if (step_done) begin
            if (ref_left != 9'h001) begin
              ref_left <= ref_left - 9'h001;
              state <= ST_REF_A;
            end else if (bursts_left != 2'h0) begin
              bursts_left <= bursts_left - 2'h1; // Second 256 burst [RULE5]
              ref_left <= dbrs_pkg::FULL_BURST_LEN;
              state <= ST_REF_A;
            end else begin
              init_done <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        ST_ROW: if (step_done) state <= ST_COL;
        ST_COL: if (step_done && phase == 4'h3) state <= ST_DONE;
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Strobes; all registered, idle high after reset [RULE16]
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      row_strobe_n_out <= dbrs_pkg::STROBE_IDLE;
      col_strobe_n_out <= dbrs_pkg::STROBE_IDLE;
      write_strobe_n_out <= dbrs_pkg::STROBE_IDLE;
    end else begin
      case (state)
        ST_REF_A: begin
          col_strobe_n_out <= 1'b0; // Row comes from memory counter [RULE2]
        end
        ST_REF_B: row_strobe_n_out <= 1'b0; // [RULE1]
        ST_REF_C: col_strobe_n_out <= 1'b1;
        ST_REF_D: row_strobe_n_out <= 1'b1;
        ST_ROW: row_strobe_n_out <= 1'b0;
        ST_COL: begin
          // Phase 0 column on bus, 1 write, 2 column strobe, 3 release
          if (phase == 4'h1 && recording) begin
            write_strobe_n_out <= 1'b0; // [RULE13]
          end
          if (phase == 4'h2) begin
            col_strobe_n_out <= 1'b0; // Column held stable here [RULE10]
          end
          if (phase == 4'h3 && step_done) begin
            write_strobe_n_out <= 1'b1;
            row_strobe_n_out <= 1'b1; // Row first, then column [RULE11]
          end
        end
        ST_DONE: col_strobe_n_out <= 1'b1; // [RULE11] [RULE13]
        default: begin
          row_strobe_n_out <= row_strobe_n_out;
        end
      endcase
    end
  end

  // Address bus: high bits cleared then merged with new part [RULE12]
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mem_addr_low_out <= 8'h00;
      mem_addr_high_out <= 2'h0;
      mem_data_out <= 1'b0;
    end else if (state == ST_IDLE && init_done && !ref_pending) begin
      mem_addr_low_out <= row_addr_low_byte;
      mem_addr_high_out <= (mem_addr_high_out & 2'h0) | row_addr_high_bits;
    end else if (state == ST_ROW && step_done) begin
      mem_addr_low_out <= col_addr_low_byte;
      mem_addr_high_out <= (mem_addr_high_out & 2'h0) | col_addr_high_bits;
      mem_data_out <= rec_bit_in; // Input bit set up with column [RULE13]
    end
  end

  // Capture memory data once the column strobe has been low a step [RULE9]
  assign capture = (state == ST_COL) && (phase == 4'h3) && step_done
    && !recording;
  assign play_word.bit_val = mem_data_in;

  // Address advance with wrap and end flag [RULE7] [RULE8]
  assign address_advance = (state == ST_DONE);
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      row_addr <= dbrs_pkg::ADDR_PART_RST;
      col_addr <= dbrs_pkg::ADDR_PART_RST;
      recording <= 1'b1;
      end_of_memory_out <= 1'b0;
    end else if (address_advance) begin
      row_addr <= next_row[9:0]; // Wraps to zero past 10 bits [RULE7]
      if (next_row[10]) begin
        col_addr <= next_col[9:0]; // [RULE8]
        if (next_col[10]) begin
          end_of_memory_out <= 1'b1;
          recording <= 1'b0; // Switch to playback forever [RULE14]
        end
      end
    end
  end

  // Playback buffer: stall by receiver loses no bit; writes bypass it
  dbrs_buf u_buf (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(capture),
    .in_ready_out(buf_ready),
    .in_data_in(play_word),
    .out_valid_out(buf_valid),
    .out_ready_in(!play_valid_out || play_ready_in),
    .out_data_out(buf_out)
  );

  // Registered playback output stage
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      play_valid_out <= 1'b0;
      play_bit_out <= 1'b0;
    end else if (!play_valid_out || play_ready_in) begin
      play_valid_out <= buf_valid;
      play_bit_out <= buf_out.bit_val;
    end
  end

endmodule : dbrs_seq

// ===== verification/dbrs_seq_properties.sv
// Checker: pin-level timing properties of the DRAM sequencer
`timescale 1ns/1ps
module dbrs_seq_chk (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Stream side
  input wire logic rec_bit_in,
  input wire logic play_valid_out,
  input wire logic play_ready_in,
  input wire logic play_bit_out,
  input wire logic end_of_memory_out,
  input wire logic full_refresh_in,
  // Memory side
  input wire logic row_strobe_n_out,
  input wire logic col_strobe_n_out,
  input wire logic write_strobe_n_out,
  input wire logic [7:0] mem_addr_low_out,
  input wire logic [1:0] mem_addr_high_out,
  input wire logic mem_data_out,
  input wire logic mem_data_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Refresh: row strobe drops under a low column strobe
  sequence s_cbr_row;
    $fell(row_strobe_n_out) && !col_strobe_n_out;
  endsequence
  // Column strobe lifts first, row strobe still low meanwhile
  sequence s_col_lifts;
    !row_strobe_n_out throughout (##[1:8] $rose(col_strobe_n_out));
  endsequence
  a_refresh_order: assert property (s_cbr_row |-> s_col_lifts)
    else $error("refresh strobe order broken");
  a_access_whole: assert property (
    $fell(row_strobe_n_out) && col_strobe_n_out |-> !row_strobe_n_out [*8])
    else $error("access cut short");
  a_access_release: assert property (
    $rose(row_strobe_n_out) && !col_strobe_n_out |=> col_strobe_n_out)
    else $error("column strobe not released after row");
  a_record_writes: assert property (
    $fell(col_strobe_n_out) && !row_strobe_n_out && !end_of_memory_out
    |-> !write_strobe_n_out)
    else $error("recording access without write strobe");
  a_write_in_row: assert property (
    !write_strobe_n_out |-> !row_strobe_n_out && $stable(mem_data_out))
    else $error("write strobe outside row phase");
  a_col_addr_held: assert property (
    $fell(col_strobe_n_out) && !row_strobe_n_out
    |-> $stable(mem_addr_low_out) && $stable(mem_addr_high_out))
    else $error("column address moved at strobe");
  a_reset_idle: assert property (
    $fell(sys_rst_in) |-> row_strobe_n_out && col_strobe_n_out
    && write_strobe_n_out && !end_of_memory_out)
    else $error("strobes not idle after reset");
  a_end_sticky: assert property (
    end_of_memory_out |=> end_of_memory_out)
    else $error("end flag dropped");
  a_no_play_rec: assert property (
    !end_of_memory_out |-> !play_valid_out)
    else $error("playback while recording");
  a_play_hold: assert property (
    play_valid_out && !play_ready_in
    |=> play_valid_out && $stable(play_bit_out))
    else $error("playback bit not held");
endmodule : dbrs_seq_chk
bind dbrs_seq dbrs_seq_chk u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .rec_bit_in(rec_bit_in), .play_valid_out(play_valid_out),
  .play_ready_in(play_ready_in), .play_bit_out(play_bit_out),
  .end_of_memory_out(end_of_memory_out), .full_refresh_in(full_refresh_in),
  .row_strobe_n_out(row_strobe_n_out), .col_strobe_n_out(col_strobe_n_out),
  .write_strobe_n_out(write_strobe_n_out), .mem_data_in(mem_data_in),
  .mem_addr_low_out(mem_addr_low_out), .mem_data_out(mem_data_out),
  .mem_addr_high_out(mem_addr_high_out));

// ===== verification/dbrs_dram_model.sv
// Partner: behavioural 1-Mbit DRAM with multiplexed address
`timescale 1ns/1ps
module dbrs_dram_model (
  // Strobes, address and data from the sequencer
  input wire logic row_strobe_n_in,
  input wire logic col_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic [9:0] addr_in,
  input wire logic data_in,
  // Data toward the sequencer
  output logic data_out,
  // Observation for the bench
  output int wr_cnt_out,
  output int ref_cnt_out,
  output int wr_row_out,
  output int wr_col_out,
  output logic wr_dat_out
);
  bit mem [int];
  int row;
  int loc;
  logic dq = 1'b0;
  initial wr_cnt_out = 0;
  initial ref_cnt_out = 0;
  // Row latch; under a low column strobe the row comes from inside
  always @(negedge row_strobe_n_in) begin
    if (col_strobe_n_in) row = addr_in;
    else ref_cnt_out++;
  end
  // Column strobe inside a row phase: write or fetch one bit
  always @(negedge col_strobe_n_in) begin
    if (!row_strobe_n_in) begin
      loc = addr_in * 1024 + row;
      if (!write_strobe_n_in) begin
        mem[loc] = data_in;
        wr_row_out = row;
        wr_col_out = addr_in;
        wr_dat_out = data_in;
        wr_cnt_out++;
      end else dq = mem.exists(loc) ? mem[loc] : ~dq;
    end
  end
  // Output floats when not strobed: show the inverse, not stale data
  assign data_out = col_strobe_n_in ? ~dq : dq;
endmodule : dbrs_dram_model

// ===== verification/tb_dbrs_seq.sv
// Testbench: recorder sequencer against DRAM model and reference
`timescale 1ns/1ps
module tb_dbrs_seq;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic rec_bit_in = 1'b0;
  logic play_ready_in = 1'b0;
  logic full_refresh_in = 1'b0;
  logic play_valid_out, play_bit_out, end_of_memory_out;
  logic row_n, col_n, wr_n, mdo, mdi, wr_dat, exp_bit;
  logic [7:0] alo;
  logic [1:0] ahi;
  int wr_cnt, ref_cnt, wr_row, wr_col, ref_base, burst, exp_addr;
  int n_errors = 0;
  int num_checks = 0;
  int seed = 32'h7c01731e;
  bit first = 1'b1;
  // 100 MHz clock
  always #5 clk_in = ~clk_in;
  dbrs_seq u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .rec_bit_in(rec_bit_in), .play_valid_out(play_valid_out),
    .play_ready_in(play_ready_in), .play_bit_out(play_bit_out),
    .end_of_memory_out(end_of_memory_out), .row_strobe_n_out(row_n),
    .col_strobe_n_out(col_n), .write_strobe_n_out(wr_n),
    .mem_addr_low_out(alo), .mem_addr_high_out(ahi),
    .mem_data_out(mdo), .mem_data_in(mdi),
    .full_refresh_in(full_refresh_in));
  dbrs_dram_model u_mem (.row_strobe_n_in(row_n), .col_strobe_n_in(col_n),
    .write_strobe_n_in(wr_n), .addr_in({ahi, alo}), .data_in(mdo),
    .data_out(mdi), .wr_cnt_out(wr_cnt), .ref_cnt_out(ref_cnt),
    .wr_row_out(wr_row), .wr_col_out(wr_col), .wr_dat_out(wr_dat));
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      n_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  task automatic test_done;
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // Inputs move 1 ns after the edge; record bit only while row is idle
  always @(posedge clk_in) begin
    #1;
    play_ready_in = 1'($random(seed));
    if (row_n) rec_bit_in = 1'($random(seed));
  end
  // Bit that the access now opening must store
  always @(negedge row_n) if (col_n === 1'b1) exp_bit = rec_bit_in;
  // Reference: linear address, row half advances first
  always @(wr_cnt) if (wr_cnt > 0) begin
    if (first) begin
      chk(ref_cnt - ref_base == burst, "refresh count");
    end
    first = 1'b0;
    chk(play_valid_out === 1'b0, "playback while recording");
    chk(wr_row == exp_addr % 1024, "row address");
    chk(wr_col == exp_addr / 1024, "column address");
    chk(wr_dat === exp_bit, "written bit");
    exp_addr++;
  end
  // Hang guard, well above the planned run
  initial begin
    repeat (40000) @(posedge clk_in);
    n_errors++;
    test_done();
  end
  // Main sequence: plain run, then a full-array refresh start
  initial begin
    ref_base = 0;
    burst = 8;
    exp_addr = 0;
    repeat (8) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    repeat (20000) @(posedge clk_in);
    chk(ref_cnt == 16, "periodic refresh bursts");
    chk(wr_cnt > 100, "recording stalled");
    chk(end_of_memory_out === 1'b0, "early end flag");
    #1 sys_rst_in = 1'b1;
    full_refresh_in = 1'b1;
    ref_base = ref_cnt;
    burst = 512;
    exp_addr = 0;
    first = 1'b1;
    repeat (2) @(posedge clk_in);
    #1 chk(row_n && col_n && wr_n, "strobes idle in reset");
    sys_rst_in = 1'b0;
    wait (!first);
    @(posedge clk_in);
    #1 full_refresh_in = 1'b0;
    repeat (500) @(posedge clk_in);
    test_done();
  end
endmodule : tb_dbrs_seq
